// *** vpa_defines.svh ***
`ifndef VPA_DEFINES_SVH
`define VPA_DEFINES_SVH

// Register offsets
`define VPA_ADDR_MISC        8'h03
`define VPA_ADDR_CLK         8'h05
`define VPA_ADDR_KILL        8'h06
`define VPA_ADDR_LUMA_A      8'h07
`define VPA_ADDR_LUMA_B      8'h08
`define VPA_ADDR_BRIGHT      8'h09
`define VPA_ADDR_SAT         8'h0A
`define VPA_ADDR_HUE         8'h0B
`define VPA_ADDR_CONTRAST    8'h0C

// Reset values
`define VPA_RST_MISC         8'h01
`define VPA_RST_CLK          8'h08
`define VPA_RST_KILL         8'h10
`define VPA_RST_LUMA_A       8'h60
`define VPA_RST_LUMA_B       8'h00
`define VPA_RST_BRIGHT       8'h80
`define VPA_RST_SAT          8'h80
`define VPA_RST_HUE          8'h00
`define VPA_RST_CONTRAST     8'h80

// Writable bits per register
`define VPA_MASK_MISC        8'h01
`define VPA_MASK_CLK         8'h0B
`define VPA_MASK_KILL        8'h7F
`define VPA_MASK_LUMA_B      8'h4C

// Field positions
`define VPA_MISC_CLK_OE      0
`define VPA_CLK_EDGE         0
`define VPA_SCLK_EDGE        1
`define VPA_SCLK_OE          3
`define VPA_KILL_MODE_HI     6
`define VPA_KILL_MODE_LO     5
`define VPA_KILL_THR_HI      4
`define VPA_LA_2X            7
`define VPA_LA_NO_PED        6
`define VPA_LA_RAW_DUMMY     5
`define VPA_LA_VB_BYPASS     4
`define VPA_LA_DELAY_HI      3
`define VPA_LB_TRAP          6
`define VPA_LB_PEAK_HI       3
`define VPA_LB_PEAK_LO       2

// Color killer modes
`define VPA_KILL_FORCE       2'h2
`define VPA_KILL_OFF         2'h3

// Picture arithmetic constants
`define VPA_NOMINAL_BLACK    20'sh00010
`define VPA_MID_CODE         20'sh00080
`define VPA_BLACK_SPAN       20'sh001B6
`define VPA_CONTRAST_MAX     8'hCF
`define VPA_CODE_MIN         20'sh00001
`define VPA_CODE_MAX         20'sh000FE
`define VPA_DUMMY_HDR        8'h40
`define VPA_CHROMA_ZERO      8'h80
`define VPA_DELAY_TAPS       9

`endif

// *** vpa_pkg.sv ***
package vpa_pkg;

  typedef enum logic [6:0] {
    VPA_IDLE     = 7'b0000001,
    VPA_ADDR     = 7'b0000010,
    VPA_ADDR_ACK = 7'b0000100,
    VPA_WDATA    = 7'b0001000,
    VPA_WACK     = 7'b0010000,
    VPA_RDATA    = 7'b0100000,
    VPA_RACK     = 7'b1000000
  } vpa_i2c_e;

  typedef struct packed {
    logic [7:0] misc;
    logic [7:0] clk_ctl;
    logic [7:0] kill;
    logic [7:0] luma_a;
    logic [7:0] luma_b;
    logic [7:0] bright;
    logic [7:0] sat;
    logic [7:0] hue;
    logic [7:0] contrast;
  } vpa_cfg_s;

  typedef struct packed {
    logic [7:0] y;
    logic [7:0] c;
  } vpa_pix_s;

  typedef struct packed {
    logic       scl_s1;
    logic       scl_s2;
    logic       scl_q;
    logic       sda_s1;
    logic       sda_s2;
    logic       sda_q;
    vpa_i2c_e   st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic       rw;
    logic [7:0] ptr;
    logic       sub_phase;
    logic       wrote;
    logic       sda_oe;
    logic       sda_o;
    vpa_cfg_s   cfg;
    vpa_cfg_s   snap;
    logic       snap_tgl;
  } vpa_core_s;

  typedef struct packed {
    logic                 rst_s1;
    logic                 rst_s2;
    logic                 tgl_s1;
    logic                 tgl_s2;
    logic                 tgl_q;
    vpa_cfg_s             cfg;
    logic                 clk_o;
    logic                 sclk_o;
    logic                 clk_oe;
    logic                 sclk_oe;
    logic                 tick;
    logic [8:0][7:0]      hist_y;
    logic [8:0][7:0]      hist_c;
    vpa_pix_s             pix;
    vpa_pix_s             spix;
    logic [7:0]           hue_out;
    logic                 trap_sel;
    logic [1:0]           peak;
  } vpa_link_s;

endpackage : vpa_pkg

// *** vpa_ctrl.sv ***
`timescale 1ns/100ps
`include "vpa_defines.svh"
// Behaviour
// RL1: control bit 0 picks main clock edge for data: 0 falling, 1 rising.
// RL2: control bit 1 picks secondary clock edge for data: 0 falling, 1 rising.
// RL3: control bit 3 enables secondary clock output; reset value 08h enables it.
// RL4: killer mode 00 auto, 10 forces zero color, 11 never kills, 01 reserved.
// RL5: five-bit threshold, 11111 -30 dB to 00000 -18 dB; auto kill compares.
// RL6: bit 7 outputs 2x luma whole frame, overriding blanking bypass.
// RL7: bit 4 outputs 2x luma only in vertical blanking, YCbCr otherwise.
// RL8: pedestal bit 0 means 7.5 IRE setup present; 1, the reset, absent.
// RL9: raw-header bit 1 replaces ancillary headers by dummy 40h bytes.
// RL10: signed four-bit luma-versus-chroma delay, -8 to +7 pixels, reset zero.
// RL11: filter select 0 comb, 1 chroma trap.
// RL12: peaking gain code 00/01/10/11 gives 0/0.5/1/2, centred 2.6 MHz.
// RL13: black level 16 + (bright-128) + 438/4 x (1 - contrast/128).
// RL14: chroma gain scales by saturation/128; zero removes colour.
// RL15: hue is signed phase offset, 7Fh +180, 00h 0, 80h -180 degrees.
// RL16: hue has no effect when the decoded standard is the FM colour one.
// RL17: luma gain scales by contrast/128; values above 207 are reserved.
// RL18: host rewrites brightness right after every contrast change; the write_mask loop writes contrast without it.
// RL19: main clock output enable is misc register bit 0, enabled after reset.
// RL20: each decoder channel has its own copy affecting only its path.
module vpa_ctrl
  import vpa_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR   = 7'h5D,
  parameter logic [7:0] PED_OFFSET = 8'h0B
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       pix_clk,
  input  wire logic [7:0] luma_in,
  input  wire logic [7:0] chroma_in,
  input  wire logic [7:0] raw_a_in,
  input  wire logic [7:0] raw_b_in,
  input  wire logic       raw_header_in,
  input  wire logic       vertical_blank_period,
  input  wire logic       secam_std,
  input  wire logic [4:0] chroma_level,
  output logic            pixel_tick,
  output logic            out_clk,
  output logic            out_clk_oe,
  output logic            sec_clk,
  output logic            sec_clk_oe,
  output logic [7:0]      y_out,
  output logic [7:0]      c_out,
  output logic [7:0]      sec_y_out,
  output logic [7:0]      sec_c_out,
  output logic [7:0]      hue_phase_out,
  output logic            luma_trap_sel,
  output logic [1:0]      peaking_gain
);

  if (PED_OFFSET > 8'h40) begin : g_chk
    $error("PED_OFFSET too large for the luma range");
  end

  localparam vpa_cfg_s CFG_RST = '{
    misc: `VPA_RST_MISC, clk_ctl: `VPA_RST_CLK, kill: `VPA_RST_KILL,
    luma_a: `VPA_RST_LUMA_A, luma_b: `VPA_RST_LUMA_B, bright: `VPA_RST_BRIGHT,
    sat: `VPA_RST_SAT, hue: `VPA_RST_HUE, contrast: `VPA_RST_CONTRAST};

  function automatic logic [7:0] reg_read(input vpa_cfg_s c, input logic [7:0] a);
    case (a)
      `VPA_ADDR_MISC:     reg_read = c.misc;
      `VPA_ADDR_CLK:      reg_read = c.clk_ctl;
      `VPA_ADDR_KILL:     reg_read = c.kill;
      `VPA_ADDR_LUMA_A:   reg_read = c.luma_a;
      `VPA_ADDR_LUMA_B:   reg_read = c.luma_b;
      `VPA_ADDR_BRIGHT:   reg_read = c.bright;
      `VPA_ADDR_SAT:      reg_read = c.sat;
      `VPA_ADDR_HUE:      reg_read = c.hue;
      `VPA_ADDR_CONTRAST: reg_read = c.contrast;
      default:            reg_read = 8'h00;
    endcase
  endfunction : reg_read

  function automatic vpa_cfg_s reg_write(input vpa_cfg_s c, input logic [7:0] a,
                                         input logic [7:0] d);
    reg_write = c;
    case (a)
      // RL19 main clock enable
      `VPA_ADDR_MISC:     reg_write.misc = d & `VPA_MASK_MISC;
      `VPA_ADDR_CLK:      reg_write.clk_ctl = d & `VPA_MASK_CLK;
      `VPA_ADDR_KILL:     reg_write.kill = d & `VPA_MASK_KILL;
      `VPA_ADDR_LUMA_A:   reg_write.luma_a = d;
      `VPA_ADDR_LUMA_B:   reg_write.luma_b = d & `VPA_MASK_LUMA_B;
      `VPA_ADDR_BRIGHT:   reg_write.bright = d;
      `VPA_ADDR_SAT:      reg_write.sat = d;
      `VPA_ADDR_HUE:      reg_write.hue = d;
      `VPA_ADDR_CONTRAST: reg_write.contrast = d;
      default:            reg_write = c;
    endcase
  endfunction : reg_write

  function automatic logic [7:0] clamp_code(input logic signed [19:0] v);
    if (v < `VPA_CODE_MIN) begin
      clamp_code = 8'h01;
    end else if (v > `VPA_CODE_MAX) begin
      clamp_code = 8'hFE;
    end else begin
      clamp_code = v[7:0];
    end
  endfunction : clamp_code

  // Serial control port, core clock domain
  vpa_core_s core;
  vpa_core_s next_core;
  logic      scl_rise;
  logic      scl_fall;
  logic      bus_start;
  logic      bus_stop;
  logic [7:0] rd_byte;

  always_comb begin
    next_core = core;
    next_core.scl_s1 = scl_in;
    next_core.scl_s2 = core.scl_s1;
    next_core.scl_q  = core.scl_s2;
    next_core.sda_s1 = sda_in;
    next_core.sda_s2 = core.sda_s1;
    next_core.sda_q  = core.sda_s2;
    next_core.sda_o  = 1'b0;
    scl_rise  = core.scl_s2 & ~core.scl_q;
    scl_fall  = ~core.scl_s2 & core.scl_q;
    bus_start = core.scl_s2 & core.scl_q & core.sda_q & ~core.sda_s2;
    bus_stop  = core.scl_s2 & core.scl_q & ~core.sda_q & core.sda_s2;
    rd_byte   = reg_read(core.cfg, core.ptr);
    if (bus_start) begin
      next_core.st        = VPA_ADDR;
      next_core.bitcnt    = 4'h0;
      next_core.sub_phase = 1'b1;
      next_core.sda_oe    = 1'b0;
    end else if (bus_stop) begin
      next_core.st     = VPA_IDLE;
      next_core.sda_oe = 1'b0;
      next_core.wrote  = 1'b0;
      // One snapshot per write transaction; contrast and brightness from two transactions apply apart
      if (core.wrote) begin
        next_core.snap     = core.cfg;
        next_core.snap_tgl = ~core.snap_tgl;
      end
    end else begin
      case (core.st)
        VPA_ADDR, VPA_WDATA: begin
          if (scl_rise) begin
            next_core.shreg  = {core.shreg[6:0], core.sda_s2};
            next_core.bitcnt = core.bitcnt + 4'h1;
          end else if (scl_fall && core.bitcnt == 4'h8) begin
            next_core.bitcnt = 4'h0;
            if (core.st == VPA_ADDR) begin
              next_core.rw     = core.shreg[0];
              next_core.sda_oe = (core.shreg[7:1] == DEV_ADDR);
              next_core.st     = (core.shreg[7:1] == DEV_ADDR) ? VPA_ADDR_ACK : VPA_IDLE;
            end else begin
              next_core.sda_oe = 1'b1;
              next_core.st     = VPA_WACK;
              if (core.sub_phase) begin
                next_core.ptr       = core.shreg;
                next_core.sub_phase = 1'b0;
              end else begin
                // RL20 own channel copy
                next_core.cfg   = reg_write(core.cfg, core.ptr, core.shreg);
                next_core.ptr   = core.ptr + 8'h01;
                next_core.wrote = 1'b1;
              end
            end
          end
        end
        VPA_ADDR_ACK: begin
          if (scl_fall) begin
            next_core.bitcnt = 4'h0;
            if (core.rw) begin
              next_core.shreg  = rd_byte;
              next_core.sda_oe = ~rd_byte[7];
              next_core.st     = VPA_RDATA;
            end else begin
              next_core.sda_oe = 1'b0;
              next_core.st     = VPA_WDATA;
            end
          end
        end
        VPA_WACK: begin
          if (scl_fall) begin
            next_core.sda_oe = 1'b0;
            next_core.st     = VPA_WDATA;
          end
        end
        VPA_RDATA: begin
          if (scl_rise) begin
            next_core.bitcnt = core.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (core.bitcnt == 4'h8) begin
              next_core.sda_oe = 1'b0;
              next_core.ptr    = core.ptr + 8'h01;
              next_core.st     = VPA_RACK;
            end else begin
              next_core.shreg  = {core.shreg[6:0], 1'b0};
              next_core.sda_oe = ~core.shreg[6];
            end
          end
        end
        VPA_RACK: begin
          if (scl_rise) begin
            next_core.shreg[0] = core.sda_s2;
          end else if (scl_fall) begin
            next_core.bitcnt = 4'h0;
            if (core.shreg[0]) begin
              next_core.st = VPA_IDLE;
            end else begin
              next_core.shreg  = rd_byte;
              next_core.sda_oe = ~rd_byte[7];
              next_core.st     = VPA_RDATA;
            end
          end
        end
        VPA_IDLE: begin
          next_core.sda_oe = 1'b0;
        end
        default: begin
          next_core.st     = VPA_IDLE;
          next_core.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      core           <= '0;
      core.scl_s1    <= 1'b1;
      core.scl_s2    <= 1'b1;
      core.scl_q     <= 1'b1;
      core.sda_s1    <= 1'b1;
      core.sda_s2    <= 1'b1;
      core.sda_q     <= 1'b1;
      core.st        <= VPA_IDLE;
      core.cfg       <= CFG_RST;
      core.snap      <= CFG_RST;
    end else begin
      core <= next_core;
    end
  end

  assign sda_out = core.sda_o;
  assign sda_oe  = core.sda_oe;

  // Video path, link clock domain
  vpa_link_s lnk;
  vpa_link_s next_lnk;
  vpa_cfg_s  lc;
  logic                update;
  logic                sec_update;
  logic signed [3:0]   dly;
  logic [3:0]          ytap;
  logic [3:0]          ctap;
  logic                bypass;
  logic                kill;
  logic [7:0]          con;
  logic signed [19:0]  yv;
  logic signed [19:0]  black;
  logic signed [19:0]  cv;
  vpa_pix_s            res;

  always_comb begin
    next_lnk = lnk;
    lc = lnk.cfg;
    next_lnk.rst_s1 = 1'b1;
    next_lnk.rst_s2 = lnk.rst_s1;
    next_lnk.tgl_s1 = core.snap_tgl;
    next_lnk.tgl_s2 = lnk.tgl_s1;
    next_lnk.tgl_q  = lnk.tgl_s2;
    // Snapshot is stable for many link cycles after its toggle moves
    if (lnk.tgl_s2 != lnk.tgl_q) begin
      next_lnk.cfg = core.snap;
    end
    // RL19 main clock enable
    next_lnk.clk_oe  = lc.misc[`VPA_MISC_CLK_OE];
    // RL3 secondary clock enable
    next_lnk.sclk_oe = lc.clk_ctl[`VPA_SCLK_OE];
    next_lnk.clk_o   = ~lnk.clk_o;
    // RL1 main data edge; a moved edge bit never gives two ticks in a row
    update = lnk.tick;
    next_lnk.tick = ~lnk.tick & (lnk.clk_o == lc.clk_ctl[`VPA_CLK_EDGE]);
    if (lnk.clk_o) begin
      next_lnk.sclk_o = ~lnk.sclk_o;
    end
    // RL2 secondary data edge
    sec_update = lnk.clk_o && (next_lnk.sclk_o == lc.clk_ctl[`VPA_SCLK_EDGE]);
    // RL10 luma-to-chroma delay
    dly  = lc.luma_a[`VPA_LA_DELAY_HI:0];
    ytap = dly[3] ? 4'h0 : {1'b0, dly[2:0]};
    ctap = dly[3] ? 4'(-dly) : 4'h0;
    // RL6 whole-frame 2x luma
    // RL7 blanking-only bypass
    bypass = lc.luma_a[`VPA_LA_2X] |
             (lc.luma_a[`VPA_LA_VB_BYPASS] & vertical_blank_period);
    // RL17 reserved contrast capped
    con = (lc.contrast > `VPA_CONTRAST_MAX) ? `VPA_CONTRAST_MAX : lc.contrast;
    yv = 20'(luma_in);
    if (ytap != 4'h0) begin
      yv = 20'(lnk.hist_y[ytap - 4'h1]);
    end
    // RL8 setup pedestal removal
    if (!lc.luma_a[`VPA_LA_NO_PED]) begin
      yv = yv - 20'(PED_OFFSET);
    end
    // RL13 black level
    black = `VPA_NOMINAL_BLACK + ($signed(20'(lc.bright)) - `VPA_MID_CODE) +
            ((`VPA_BLACK_SPAN * (`VPA_MID_CODE - $signed(20'(con)))) >>> 9);
    // RL17 luma gain
    yv = black + (((yv - `VPA_NOMINAL_BLACK) * $signed(20'(con))) >>> 7);
    cv = 20'(chroma_in);
    if (ctap != 4'h0) begin
      cv = 20'(lnk.hist_c[ctap - 4'h1]);
    end
    // RL5 threshold compare
    // RL4 killer modes
    case (lc.kill[`VPA_KILL_MODE_HI:`VPA_KILL_MODE_LO])
      `VPA_KILL_FORCE: kill = 1'b1;
      `VPA_KILL_OFF:   kill = 1'b0;
      default:         kill = (chroma_level > lc.kill[`VPA_KILL_THR_HI:0]);
    endcase
    // RL14 saturation gain
    cv = `VPA_MID_CODE + (((cv - `VPA_MID_CODE) * $signed(20'(lc.sat))) >>> 7);
    res.y = clamp_code(yv);
    res.c = kill ? `VPA_CHROMA_ZERO : clamp_code(cv);
    if (bypass) begin
      res.y = raw_a_in;
      res.c = raw_b_in;
      // RL9 dummy ancillary headers
      if (raw_header_in && lc.luma_a[`VPA_LA_RAW_DUMMY]) begin
        res.y = `VPA_DUMMY_HDR;
        res.c = `VPA_DUMMY_HDR;
      end
    end
    if (update) begin
      next_lnk.hist_y = {lnk.hist_y[7:0], luma_in};
      next_lnk.hist_c = {lnk.hist_c[7:0], chroma_in};
      next_lnk.pix    = res;
    end
    if (sec_update) begin
      next_lnk.spix = lnk.pix;
    end
    // RL16 hue ignored for FM colour
    // RL15 signed phase offset
    next_lnk.hue_out  = secam_std ? 8'h00 : lc.hue;
    // RL11 comb or trap
    next_lnk.trap_sel = lc.luma_b[`VPA_LB_TRAP];
    // RL12 peaking gain code
    next_lnk.peak     = lc.luma_b[`VPA_LB_PEAK_HI:`VPA_LB_PEAK_LO];
  end

  always_ff @(posedge pix_clk) begin
    if (!lnk.rst_s2) begin
      lnk         <= '0;
      lnk.rst_s1  <= 1'b1;
      lnk.rst_s2  <= lnk.rst_s1;
      lnk.tgl_s1  <= core.snap_tgl;
      lnk.cfg     <= CFG_RST;
    end else begin
      lnk <= next_lnk;
    end
    if (!reset_n) begin
      lnk.rst_s1 <= 1'b0;
      lnk.rst_s2 <= 1'b0;
    end
  end

  assign pixel_tick    = lnk.tick;
  assign out_clk       = lnk.clk_o;
  assign out_clk_oe    = lnk.clk_oe;
  assign sec_clk       = lnk.sclk_o;
  assign sec_clk_oe    = lnk.sclk_oe;
  assign y_out         = lnk.pix.y;
  assign c_out         = lnk.pix.c;
  assign sec_y_out     = lnk.spix.y;
  assign sec_c_out     = lnk.spix.c;
  assign hue_phase_out = lnk.hue_out;
  assign luma_trap_sel = lnk.trap_sel;
  assign peaking_gain  = lnk.peak;

endmodule : vpa_ctrl

// *** vpa_ctrl_sva.sv ***
`timescale 1ns/100ps
module vpa_ctrl_sva (
  input wire logic       pix_clk,
  input wire logic       reset_n,
  input wire logic       pixel_tick,
  input wire logic       out_clk,
  input wire logic       sec_clk,
  input wire logic       secam_std,
  input wire logic [7:0] y_out,
  input wire logic [7:0] c_out,
  input wire logic [7:0] sec_y_out,
  input wire logic [7:0] sec_c_out,
  input wire logic [7:0] hue_phase_out
);
  default clocking cb @(posedge pix_clk); endclocking
  default disable iff (!reset_n);

  sequence s_tick_step;
    pixel_tick ##1 !pixel_tick;
  endsequence
  sequence s_sec_hold;
    $changed(sec_clk) ##1 $stable(sec_clk);
  endsequence

  property p_tick_alt;
    pixel_tick |-> s_tick_step;
  endproperty
  property p_y_tick;
    $changed(y_out) |-> $past(pixel_tick);
  endproperty
  property p_c_tick;
    $changed(c_out) |-> $past(pixel_tick);
  endproperty
  property p_out_pulse;
    $rose(out_clk) |=> $fell(out_clk);
  endproperty
  property p_sec_half;
    $changed(sec_clk) |-> s_sec_hold;
  endproperty
  property p_sec_moves;
    $changed(sec_y_out) |-> $changed(sec_clk);
  endproperty
  property p_sec_copy;
    $changed(sec_y_out) |-> sec_y_out == $past(y_out);
  endproperty
  property p_sec_c_copy;
    $changed(sec_c_out) |-> sec_c_out == $past(c_out);
  endproperty
  // Registered hue needs the standard flag to have settled first
  property p_hue_secam;
    secam_std [*3] |-> hue_phase_out == 8'h00;
  endproperty

  a_tick_alt:   assert property (p_tick_alt)   else $error("pixel tick not alternating");
  a_y_tick:     assert property (p_y_tick)     else $error("luma changed off tick");
  a_c_tick:     assert property (p_c_tick)     else $error("chroma changed off tick");
  a_out_pulse:  assert property (p_out_pulse)  else $error("main clock not toggling");
  a_sec_half:   assert property (p_sec_half)   else $error("second clock rate wrong");
  a_sec_moves:  assert property (p_sec_moves)  else $error("second data off its clock");
  a_sec_copy:   assert property (p_sec_copy)   else $error("second data not a copy");
  a_hue_secam:  assert property (p_hue_secam)  else $error("hue not zeroed");
  a_sec_c_copy: assert property (p_sec_c_copy) else $error("second chroma not a copy");
endmodule : vpa_ctrl_sva

bind vpa_ctrl vpa_ctrl_sva sva_u (
  .pix_clk(pix_clk), .reset_n(reset_n), .pixel_tick(pixel_tick), .out_clk(out_clk),
  .sec_clk(sec_clk), .secam_std(secam_std), .y_out(y_out), .c_out(c_out),
  .sec_y_out(sec_y_out), .sec_c_out(sec_c_out), .hue_phase_out(hue_phase_out)
);

// *** vpa_host_model.sv ***
`timescale 1ns/100ps
module vpa_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h5D
) (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Four core clocks keeps each bus phase above the synchroniser lag
  task automatic half();
    repeat (4) @(posedge clk);
  endtask : half

  task automatic bit_io(input logic b, output logic r);
    half();
    sda_pull <= ~b;
    half();
    scl <= 1'b1;
    half();
    r = sda;
    scl <= 1'b0;
  endtask : bit_io

  task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'b1, r);
  endtask : byte_io

  task automatic start();
    half();
    sda_pull <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_pull <= 1'b1;
    half();
    scl <= 1'b0;
  endtask : start

  task automatic stop();
    half();
    sda_pull <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_pull <= 1'b0;
    half();
  endtask : stop

  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] q;
    start();
    byte_io({DEV_ADDR, 1'b0}, q);
    byte_io(ptr, q);
    byte_io(d, q);
    stop();
  endtask : write_reg

  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] q);
    logic [7:0] dummy;
    start();
    byte_io({DEV_ADDR, 1'b0}, dummy);
    byte_io(ptr, dummy);
    start();
    byte_io({DEV_ADDR, 1'b1}, dummy);
    byte_io(8'hFF, q);
    stop();
  endtask : read_reg

  task automatic set_picture(input logic [7:0] con, input logic [7:0] bri);
    write_reg(8'h0C, con);
    write_reg(8'h09, bri);
  endtask : set_picture
endmodule : vpa_host_model

// *** vpa_ctrl_tb.sv ***
`timescale 1ns/100ps
module vpa_ctrl_tb;
  import vpa_pkg::*;
  localparam logic [7:0] OFFS [10] = '{8'h03, 8'h05, 8'h06, 8'h07, 8'h08,
                                       8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h20};
  localparam logic [7:0] RSTV [10] = '{8'h01, 8'h08, 8'h10, 8'h60, 8'h00,
                                       8'h80, 8'h80, 8'h00, 8'h80, 8'h00};
  localparam logic [7:0] MASK [10] = '{8'h01, 8'h0B, 8'h7F, 8'hFF, 8'h4C,
                                       8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
  logic       clk, reset_n, pix_clk, scl_w, sda_w, sda_pull, sda_out, sda_oe;
  logic       pixel_tick, out_clk, out_clk_oe, sec_clk, sec_clk_oe, trap;
  logic       raw_hdr, vblank, secam;
  logic [7:0] luma_in, chroma_in, raw_a, raw_b, y_out, c_out, sy, sc, hue_o;
  logic [4:0] level;
  logic [1:0] peak;
  logic [7:0] cfg [13];
  int         fails, num_checks, seed;
  int         hy [$], hc [$];

  vpa_ctrl dut_u (
    .clk(clk), .reset_n(reset_n), .scl_in(scl_w), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .pix_clk(pix_clk), .luma_in(luma_in), .chroma_in(chroma_in),
    .raw_a_in(raw_a), .raw_b_in(raw_b), .raw_header_in(raw_hdr),
    .vertical_blank_period(vblank), .secam_std(secam), .chroma_level(level),
    .pixel_tick(pixel_tick), .out_clk(out_clk), .out_clk_oe(out_clk_oe),
    .sec_clk(sec_clk), .sec_clk_oe(sec_clk_oe), .y_out(y_out), .c_out(c_out),
    .sec_y_out(sy), .sec_c_out(sc), .hue_phase_out(hue_o), .luma_trap_sel(trap),
    .peaking_gain(peak)
  );
  vpa_host_model host_u (.clk(clk), .sda(sda_w), .scl(scl_w), .sda_pull(sda_pull));
  // Open-drain data line with pull-up
  assign sda_w = ~((sda_oe & ~sda_out) | sda_pull);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    pix_clk = 1'b0;
    #1.3;
    forever #3 pix_clk = ~pix_clk;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [7:0] clip(input int v);
    return (v < 1) ? 8'h01 : (v > 254) ? 8'hFE : 8'(v);
  endfunction : clip

  task automatic pixel();
    logic [7:0] yv, cv, ra, rb;
    logic       hd, vb, sm;
    logic [4:0] lv;
    logic [1:0] m;
    int         con, bri, ey, ec, d, ys, cs;
    {yv, cv, ra, rb} = $random(seed);
    {hd, vb, sm, lv} = 8'($random(seed));
    @(posedge pix_clk);
    luma_in <= yv;
    chroma_in <= cv;
    raw_a <= ra;
    raw_b <= rb;
    raw_hdr <= hd;
    vblank <= vb;
    secam <= sm;
    level <= lv;
    d = cfg[7][3] ? int'(cfg[7][3:0]) - 16 : int'(cfg[7][3:0]);
    ys = (d > 0) ? hy[d - 1] : int'(yv);
    cs = (d < 0) ? hc[-d - 1] : int'(cv);
    hy.push_front(int'(yv));
    hc.push_front(int'(cv));
    if (hy.size() > 8) begin
      void'(hy.pop_back());
      void'(hc.pop_back());
    end
    con = (cfg[12] > 8'd207) ? 207 : cfg[12];
    bri = cfg[9];
    ys = cfg[7][6] ? ys : ys - 11;
    ey = clip(16 + bri - 128 + ((438 * (128 - con)) >>> 9) + (((ys - 16) * con) >>> 7));
    m = cfg[6][6:5];
    ec = (m == 2'b10 || (m != 2'b11 && lv > cfg[6][4:0])) ? 128 :
         clip(128 + (((cs - 128) * int'(cfg[10])) >>> 7));
    if (cfg[7][7] || (cfg[7][4] && vb)) begin
      ey = (hd && cfg[7][5]) ? 64 : ra;
      ec = (hd && cfg[7][5]) ? 64 : rb;
    end
    @(negedge pix_clk);
    if (pixel_tick !== 1'b1) @(negedge pix_clk);
    @(posedge pix_clk);
    @(negedge pix_clk);
    chk("y_out", 8'(ey), y_out);
    chk("c_out", 8'(ec), c_out);
    chk("hue", sm ? 8'h00 : cfg[11], hue_o);
    chk("clock_bits", {2'b00, cfg[8][6], cfg[8][3:2], cfg[3][0], cfg[5][3], cfg[5][0]},
        {2'b00, trap, peak, out_clk_oe, sec_clk_oe, out_clk});
  endtask : pixel

  task automatic setup(input int i);
    logic [7:0] r [8];
    foreach (r[k]) r[k] = 8'($random(seed));
    cfg[3] = r[0] & 8'h01;
    cfg[5] = r[1] & 8'h0B;
    cfg[6] = 8'(i % 4 << 5) | (r[2] & 8'h1F);
    cfg[7] = r[3];
    cfg[8] = r[4] & 8'h4C;
    cfg[9] = r[5];
    cfg[10] = (i == 2) ? 8'h00 : r[6];
    cfg[11] = r[7];
    cfg[12] = (i == 1) ? 8'hFF : 8'($random(seed));
    for (int k = 3; k < 12; k++) begin
      if (k != 4 && k != 9) host_u.write_reg(8'(k), cfg[k]);
    end
    host_u.set_picture(cfg[12], cfg[9]);
    repeat (30) @(posedge pix_clk);
    // Idle updates fill the history with the held sample
    hy = {};
    hc = {};
    repeat (8) begin
      hy.push_front(int'(luma_in));
      hc.push_front(int'(chroma_in));
    end
  endtask : setup

  task automatic report_and_stop();
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #800000;
    fails++;
    report_and_stop();
  end

  initial begin
    logic [7:0] q;
    seed = 32'h474cc224;
    fails = 0;
    num_checks = 0;
    reset_n = 1'b0;
    {luma_in, chroma_in, raw_a, raw_b} = 32'h0;
    {raw_hdr, vblank, secam, level} = 8'h00;
    foreach (cfg[k]) cfg[k] = 8'h00;
    for (int k = 0; k < 9; k++) cfg[OFFS[k]] = RSTV[k];
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk);
    for (int k = 0; k < 10; k++) begin
      host_u.read_reg(OFFS[k], q);
      chk("reset_value", RSTV[k], q);
    end
    repeat (4) pixel();
    for (int k = 0; k < 10; k++) begin
      host_u.write_reg(OFFS[k], 8'hFF);
      host_u.read_reg(OFFS[k], q);
      chk("write_mask", MASK[k], q);
      host_u.write_reg(OFFS[k], RSTV[k]);
    end
    for (int i = 0; i < 10; i++) begin
      setup(i);
      repeat (8) pixel();
    end
    report_and_stop();
  end
endmodule : vpa_ctrl_tb
